//--- gpc_board.sv
`timescale 1ns/100ps
module gpc_board (
    input  wire logic                     hclk,
    input  wire logic [gpc_pkg::NPIN-1:0] pad_out,
    input  wire logic [gpc_pkg::NPIN-1:0] pad_oe,
    input  wire logic [gpc_pkg::NPIN-1:0] pad_pullup,
    input  wire logic [gpc_pkg::NPIN-1:0] ext_en,
    input  wire logic [gpc_pkg::NPIN-1:0] ext_val,
    output logic      [gpc_pkg::NPIN-1:0] pad_in
);
    import gpc_pkg::*;

    logic [NPIN-1:0] last_r;

    // ------------------------------------------------------------------
    // wire level: driver, then board, then pull-up, else floating
    // ------------------------------------------------------------------
    always_comb begin
        for (int n = 0; n < NPIN; n++) begin
            if (pad_oe[n]) begin
                pad_in[n] = pad_out[n];
            end else if (ext_en[n]) begin
                pad_in[n] = ext_val[n];
            end else if (pad_pullup[n]) begin
                pad_in[n] = 1'b1;
            end else begin
                // floating line wanders every cycle
                pad_in[n] = ~last_r[n];
            end
        end
    end

    always_ff @(posedge hclk) begin
        last_r <= pad_in;
    end
endmodule

//--- gpc_pkg.sv
package gpc_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int NGRP   = 3;
    localparam int PW     = 8;
    localparam int NPIN   = NGRP * PW;
    localparam int IDX_W  = 10;
    localparam int HADDR_LSB = 2;

    // pin 15 does not exist; group 1 holds pins 14..8 only
    localparam logic [NPIN-1:0] PIN_MASK = 24'hff7fff;

    // ------------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [NGRP-1:0][IDX_W-1:0] IDX_PIN  =
        {10'h029, 10'h026, 10'h023};
    localparam logic [NGRP-1:0][IDX_W-1:0] IDX_DIR  =
        {10'h02a, 10'h027, 10'h024};
    localparam logic [NGRP-1:0][IDX_W-1:0] IDX_OUT  =
        {10'h02b, 10'h028, 10'h025};
    localparam logic [NGRP-1:0][IDX_W-1:0] IDX_MASK =
        {10'h06d, 10'h06c, 10'h06b};
    localparam logic [IDX_W-1:0] IDX_FLAGS     = 10'h03b;
    localparam logic [IDX_W-1:0] IDX_CORE_CTRL = 10'h055;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 10'h05f;
    localparam logic [IDX_W-1:0] IDX_CTRL      = 10'h068;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int PUD_BIT = 4;
    localparam int GIE_BIT = 7;
    localparam logic [NPIN-1:0] RST_PINS = 24'h000000;
    localparam logic [NGRP-1:0] RST_GRP  = 3'h0;
    localparam logic [31:0]     RDATA_UNMAPPED = 32'h00000000;

    // ------------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'b0;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_DATA = 1'b1
    } gpc_bus_e;

endpackage

//--- gpc_port_top.sv
// Functional notes
// - masked change in a group sets that group's flag bit 2, 1 or 0.
// - flag with global and group enable requests vector; handler ack clears it.
// - writing one to a flag bit clears it; zero leaves it.
// - flag register bits 7 to 3 always read zero.
// - group 2 mask, eight bits, reset zero, enables detection with group enable.
// - group 1 mask has bits 6 to 0; bit 7 reads zero.
// - group 0 mask, eight bits, reset zero, enables detection with group enable.
// - cleared mask bit keeps its pin out of the group request.
// - each port has data and direction read/write, input read-only.
// - writing one to the input location toggles the output data bit.
// - global pull-up disable turns off every pull-up.
// - direction one makes an output, zero an input.
// - input pull-up only when data one and pull-up disable zero.
// - output driven to data bit; pull-up always off for outputs.
// - reset tri-states all pins at once, without a clock.
// - pin level readable through input bit for any direction.
// - sync latch holds at falling edge; input bit loads at rising edge.
// - external transition reaches input bit after half to one and half periods.
// - own written value reaches input bit after one clock period.
// - a write changes only the bits of the addressed register.
// - each group has its own enable bit in the control register.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/100ps
module gpc_port_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [ADDR_W-1:0]        haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire logic [gpc_pkg::NPIN-1:0] pad_in,
    output logic      [gpc_pkg::NPIN-1:0] pad_out,
    output logic      [gpc_pkg::NPIN-1:0] pad_oe,
    output logic      [gpc_pkg::NPIN-1:0] pad_pullup,
    output logic      [gpc_pkg::NGRP-1:0] irq_req,
    input  wire logic [gpc_pkg::NGRP-1:0] irq_ack
);
    import gpc_pkg::*;

    generate
        if (ADDR_W < 9 || ADDR_W > 12) begin : g_chk
            $error("gpc_port_top: ADDR_W must be 9 to 12");
        end
    endgenerate

    function automatic logic [31:0] zx(input logic [PW-1:0] b);
        return {24'h000000, b};
    endfunction

    gpc_bus_e          state_r, state_nxt;
    logic [IDX_W-1:0]  addr_r, addr_nxt;
    logic              wr_r, wr_nxt;
    logic              hreadyout_r, hreadyout_nxt;
    logic [31:0]       hrdata_r, hrdata_nxt;
    logic [31:0]       rd_word;
    logic [NPIN-1:0]   dir_r, dir_nxt;
    logic [NPIN-1:0]   out_r, out_nxt;
    logic [NPIN-1:0]   mask_r, mask_nxt;
    logic [NPIN-1:0]   pull_r, pull_nxt;
    logic [NPIN-1:0]   prev_r;
    logic [NPIN-1:0]   pin_sync;
    logic [NPIN-1:0]   chg;
    logic [NGRP-1:0]   flag_r, flag_nxt;
    logic [NGRP-1:0]   ctrl_r, ctrl_nxt;
    logic [NGRP-1:0]   irq_r, irq_nxt;
    logic [NGRP-1:0]   grp_set;
    logic [NGRP-1:0]   flag_clr;
    logic              pud_r, pud_nxt;
    logic              gie_r, gie_nxt;
    logic              take;
    logic              wr_now;

    // ------------------------------------------------------------------
    // input synchronizer and change detection
    // ------------------------------------------------------------------
    gpc_sync #(
        .W (NPIN)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (pad_in),
        .q     (pin_sync)
    );

    always_comb begin
        chg = (pin_sync ^ prev_r) & mask_r & PIN_MASK;
        for (int g = 0; g < NGRP; g++) begin
            grp_set[g] = ctrl_r[g] & (|chg[g*PW +: PW]);
        end
    end

    // ------------------------------------------------------------------
    // bus slave: one wait cycle in every word-sized data phase
    // ------------------------------------------------------------------
    assign take   = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
    assign wr_now = (state_r == BUS_DATA) & wr_r;

    always_comb begin
        rd_word = RDATA_UNMAPPED;
        for (int g = 0; g < NGRP; g++) begin
            if (addr_r == IDX_PIN[g]) begin
                rd_word = zx(pin_sync[g*PW +: PW]);
            end
            if (addr_r == IDX_DIR[g]) begin
                rd_word = zx(dir_r[g*PW +: PW]);
            end
            if (addr_r == IDX_OUT[g]) begin
                rd_word = zx(out_r[g*PW +: PW]);
            end
            if (addr_r == IDX_MASK[g]) begin
                rd_word = zx(mask_r[g*PW +: PW]);
            end
        end
        if (addr_r == IDX_FLAGS) begin
            rd_word = zx({5'h00, flag_r});
        end
        if (addr_r == IDX_CTRL) begin
            rd_word = zx({5'h00, ctrl_r});
        end
        if (addr_r == IDX_CORE_CTRL) begin
            rd_word[PUD_BIT] = pud_r;
        end
        if (addr_r == IDX_STATUS) begin
            rd_word[GIE_BIT] = gie_r;
        end
    end

    always_comb begin
        state_nxt     = state_r;
        addr_nxt      = addr_r;
        wr_nxt        = wr_r;
        hreadyout_nxt = 1'b1;
        hrdata_nxt    = hrdata_r;
        unique case (state_r)
            BUS_IDLE: begin
                if (take) begin
                    state_nxt     = BUS_DATA;
                    addr_nxt      = IDX_W'(haddr[ADDR_W-1:HADDR_LSB]);
                    wr_nxt        = hwrite;
                    hreadyout_nxt = 1'b0;
                end
            end
            BUS_DATA: begin
                state_nxt = BUS_IDLE;
                if (!wr_r) begin
                    hrdata_nxt = rd_word;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= BUS_IDLE;
            addr_r      <= '0;
            wr_r        <= 1'b0;
            hreadyout_r <= 1'b1;
            hrdata_r    <= RDATA_UNMAPPED;
        end else begin
            state_r     <= state_nxt;
            addr_r      <= addr_nxt;
            wr_r        <= wr_nxt;
            hreadyout_r <= hreadyout_nxt;
            hrdata_r    <= hrdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // port, mask, flag and control registers
    // ------------------------------------------------------------------
    always_comb begin
        dir_nxt  = dir_r;
        out_nxt  = out_r;
        mask_nxt = mask_r;
        ctrl_nxt = ctrl_r;
        pud_nxt  = pud_r;
        gie_nxt  = gie_r;
        flag_clr = irq_ack;
        if (wr_now) begin
            for (int g = 0; g < NGRP; g++) begin
                if (addr_r == IDX_DIR[g]) begin
                    dir_nxt[g*PW +: PW] =
                        hwdata[PW-1:0] & PIN_MASK[g*PW +: PW];
                end
                if (addr_r == IDX_OUT[g]) begin
                    out_nxt[g*PW +: PW] =
                        hwdata[PW-1:0] & PIN_MASK[g*PW +: PW];
                end
                if (addr_r == IDX_PIN[g]) begin
                    out_nxt[g*PW +: PW] = out_r[g*PW +: PW]
                        ^ (hwdata[PW-1:0] & PIN_MASK[g*PW +: PW]);
                end
                if (addr_r == IDX_MASK[g]) begin
                    mask_nxt[g*PW +: PW] =
                        hwdata[PW-1:0] & PIN_MASK[g*PW +: PW];
                end
            end
            if (addr_r == IDX_FLAGS) begin
                flag_clr = flag_clr | hwdata[NGRP-1:0];
            end
            if (addr_r == IDX_CTRL) begin
                ctrl_nxt = hwdata[NGRP-1:0];
            end
            if (addr_r == IDX_CORE_CTRL) begin
                pud_nxt = hwdata[PUD_BIT];
            end
            if (addr_r == IDX_STATUS) begin
                gie_nxt = hwdata[GIE_BIT];
            end
        end
        // set wins over any clear in the same cycle
        flag_nxt = (flag_r & ~flag_clr) | grp_set;
        irq_nxt  = flag_nxt & ctrl_nxt & {NGRP{gie_nxt}};
        pull_nxt = ~dir_nxt & out_nxt & {NPIN{~pud_nxt}}
                   & PIN_MASK;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_r  <= RST_PINS;
            out_r  <= RST_PINS;
            mask_r <= RST_PINS;
            pull_r <= RST_PINS;
            prev_r <= RST_PINS;
            flag_r <= RST_GRP;
            ctrl_r <= RST_GRP;
            irq_r  <= RST_GRP;
            pud_r  <= 1'b0;
            gie_r  <= 1'b0;
        end else begin
            dir_r  <= dir_nxt;
            out_r  <= out_nxt;
            mask_r <= mask_nxt;
            pull_r <= pull_nxt;
            prev_r <= pin_sync;
            flag_r <= flag_nxt;
            ctrl_r <= ctrl_nxt;
            irq_r  <= irq_nxt;
            pud_r  <= pud_nxt;
            gie_r  <= gie_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hrdata     = hrdata_r;
    assign hreadyout  = hreadyout_r;
    assign hresp      = HRESP_OKAY;
    assign pad_out    = out_r;
    assign pad_oe     = dir_r;
    assign pad_pullup = pull_r;
    assign irq_req    = irq_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_flag_set_group: assert property (
        grp_set[0] |=> flag_r[0])
        else $error("group 0 change did not set its flag");

    a_flag_w1c_clear: assert property (
        wr_now && addr_r == IDX_FLAGS && hwdata[1] && !grp_set[1]
        |=> !flag_r[1])
        else $error("write one did not clear flag 1");

    a_flag_w0_keep: assert property (
        wr_now && addr_r == IDX_FLAGS && !hwdata[2] && flag_r[2]
        && !irq_ack[2] |=> flag_r[2])
        else $error("write zero disturbed flag 2");

    a_flags_rsvd_zero: assert property (
        state_r == BUS_DATA && !wr_r && addr_r == IDX_FLAGS
        |=> hreadyout && hrdata[31:3] == 29'h0)
        else $error("flag register reserved bits not zero");

    a_mask1_top_bit: assert property (
        !mask_r[15] && !pad_out[15])
        else $error("nonexistent pin 15 bit became set");

    a_mask_blocks_chg: assert property (
        mask_r[7:0] == 8'h00 && !flag_r[0] && !wr_now |=> !flag_r[0])
        else $error("masked pins raised group 0 flag");

    a_pin_toggle_out: assert property (
        wr_now && addr_r == IDX_PIN[0]
        |=> out_r[7:0] == ($past(out_r[7:0]) ^ $past(hwdata[7:0])))
        else $error("input location write did not toggle data");

    a_pullup_table: assert property (
        pad_pullup == (~pad_oe & pad_out & {NPIN{~pud_r}}))
        else $error("pull-up state does not match pin setup");

    a_sync_one_cycle: assert property (
        pin_sync[3] == $past(pad_in[3]))
        else $error("input bit not one period behind pin");

    a_irq_gating: assert property (
        irq_req == (flag_r & ctrl_r & {NGRP{gie_r}}))
        else $error("interrupt request gating wrong");

    a_ack_clears: assert property (
        irq_ack[1] && !grp_set[1] |=> !flag_r[1] && !irq_req[1])
        else $error("handler ack did not clear flag 1");

    a_bus_wait_one: assert property (
        take && state_r == BUS_IDLE |=> !hreadyout ##1 hreadyout)
        else $error("data phase not exactly one wait cycle");

    c_flag_raised: cover property (grp_set[2] ##1 flag_r[2]);
    c_irq_raised: cover property (!irq_req[0] ##1 irq_req[0]);
    c_pin_toggle: cover property (wr_now && addr_r == IDX_PIN[1]);
    c_flags_read: cover property (
        state_r == BUS_DATA && !wr_r && addr_r == IDX_FLAGS);

endmodule

//--- gpc_sync.sv
`timescale 1ns/100ps
module gpc_sync #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    generate
        if (W < 1) begin : g_chk
            $error("gpc_sync: width must be at least one");
        end
    endgenerate

    logic [W-1:0] stage_r;
    logic [W-1:0] q_r;

    // ------------------------------------------------------------------
    // falling-edge stage stands in for the high-transparent latch
    // ------------------------------------------------------------------
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= '0;
        end else begin
            stage_r <= d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= stage_r;
        end
    end

    assign q = q_r;

endmodule

//--- gpio_port_pin_change_irq_tb_top.sv
`timescale 1ns/100ps
module gpio_port_pin_change_irq_tb_top;
    import gpc_pkg::*;

    logic            hclk;
    logic            hresetn;
    logic            hsel;
    logic [11:0]     haddr;
    logic [1:0]      htrans;
    logic            hwrite;
    logic [2:0]      hsize;
    logic [31:0]     hwdata;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic [NPIN-1:0] pad_in;
    logic [NPIN-1:0] pad_out;
    logic [NPIN-1:0] pad_oe;
    logic [NPIN-1:0] pad_pullup;
    logic [NPIN-1:0] ext_en;
    logic [NPIN-1:0] ext_val;
    logic [NGRP-1:0] irq_req;
    logic [NGRP-1:0] irq_ack;
    int              errors;
    int              checks;
    int              p;

    gpc_port_top #(.ADDR_W(12)) gpc_port_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pullup(pad_pullup), .irq_req(irq_req),
        .irq_ack(irq_ack)
    );

    gpc_board gpc_board_i (
        .hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy(inout int n);
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
    endtask

    task automatic bus(input logic wr, input logic [9:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {idx, 2'h0};
        hwrite <= wr;
        wait_rdy(n);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(n);
        rd = hrdata;
        if (n >= 40) begin
            errors++;
            $display("wrong value at %0t: bus hang", $time);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, idx, d, rd);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0, rd);
        chk(rd, exp);
    endtask

    task automatic flip(input int pin);
        ext_val[pin] <= ~ext_val[pin];
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        #(40 * 20000);
        errors++;
        $display("wrong value at %0t: timeout", $time);
        end_of_test();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        errors = 0;
        checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        irq_ack = 3'h0;
        ext_en = '1;
        ext_val = '0;
        repeat (4) @(posedge hclk);
        chk({8'h0, pad_oe | pad_pullup}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({31'h0, hresp}, 32'h0);
        rd_chk(IDX_FLAGS, 32'h0);
        for (int g = 0; g < NGRP; g++) begin
            rd_chk(IDX_OUT[g], 32'h0);
            rd_chk(IDX_DIR[g], 32'h0);
            rd_chk(IDX_MASK[g], 32'h0);
            wr(IDX_MASK[g], 32'hffffffff);
            rd_chk(IDX_MASK[g], (g == 1) ? 32'h7f : 32'hff);
            wr(IDX_MASK[g], 32'h0);
        end
        wr(10'h3f0, 32'hff);
        rd_chk(10'h3f0, RDATA_UNMAPPED);
        // data first, so no pin jumps from tri-state to output high
        wr(IDX_OUT[0], 32'hcc);
        chk({8'h0, pad_pullup}, 32'hcc);
        wr(IDX_DIR[0], 32'hf0);
        chk({8'h0, pad_oe}, 32'hf0);
        chk({28'h0, pad_out[7:4]}, 32'hc);
        chk({8'h0, pad_pullup}, 32'h0c);
        rd_chk(IDX_PIN[0], 32'hc0);
        wr(IDX_CORE_CTRL, 32'h1 << PUD_BIT);
        chk({8'h0, pad_pullup}, 32'h0);
        wr(IDX_CORE_CTRL, 32'h0);
        wr(IDX_PIN[0], 32'h0f);
        rd_chk(IDX_OUT[0], 32'hc3);
        wr(IDX_PIN[0], 32'h00);
        rd_chk(IDX_OUT[0], 32'hc3);
        rd_chk(IDX_DIR[0], 32'hf0);
        rd_chk(IDX_PIN[0], 32'hc0);
        chk({8'h0, pad_pullup}, 32'h03);
        // board lets go of pins 1:0, only the pull-ups hold them high
        ext_en[1:0] <= 2'h0;
        rd_chk(IDX_PIN[0], 32'hc3);
        ext_en <= '1;
        wr(IDX_DIR[1], 32'h01);
        chk({8'h0, pad_oe}, 32'h0001f0);
        wr(IDX_DIR[1], 32'h0);
        wr(IDX_STATUS, 32'h1 << GIE_BIT);
        for (int g = 0; g < NGRP; g++) begin
            p = g * PW;
            wr(IDX_MASK[g], 32'h01);
            wr(IDX_CTRL, 32'h1 << g);
            flip(p + 1);
            repeat (4) @(posedge hclk);
            rd_chk(IDX_FLAGS, 32'h0);
            flip(p);
            @(posedge hclk);
            #1 chk({29'h0, irq_req}, 32'h0);
            @(posedge hclk);
            #1 chk({29'h0, irq_req}, 32'h1 << g);
            rd_chk(IDX_FLAGS, 32'h1 << g);
            wr(IDX_FLAGS, 32'h0);
            rd_chk(IDX_FLAGS, 32'h1 << g);
            wr(IDX_FLAGS, 32'hff);
            rd_chk(IDX_FLAGS, 32'h0);
            flip(p);
            repeat (3) @(posedge hclk);
            chk({29'h0, irq_req}, 32'h1 << g);
            irq_ack <= 3'h1 << g;
            @(posedge hclk);
            irq_ack <= 3'h0;
            @(posedge hclk);
            #1 chk({29'h0, irq_req}, 32'h0);
            rd_chk(IDX_FLAGS, 32'h0);
            wr(IDX_CTRL, 32'h0);
            flip(p);
            repeat (4) @(posedge hclk);
            rd_chk(IDX_FLAGS, 32'h0);
            wr(IDX_MASK[g], 32'h0);
        end
        wr(IDX_STATUS, 32'h0);
        wr(IDX_MASK[0], 32'h01);
        wr(IDX_CTRL, 32'h1);
        flip(0);
        repeat (4) @(posedge hclk);
        chk({29'h0, irq_req}, 32'h0);
        rd_chk(IDX_FLAGS, 32'h1);
        // reset must release the pins before any further clock edge
        hresetn <= 1'b0;
        #1 chk({8'h0, pad_oe | pad_pullup}, 32'h0);
        end_of_test();
    end
endmodule
